// ==== logic/rx_filter_pkg.sv ====
// Purpose: Constants and carriers for the receive filter and VLAN tables
// Assumes: 32-bit register port, 256 KB register window
// Notes: Offsets are byte addresses within the window
`default_nettype none
package rx_filter_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register port geometry
   localparam int ADDR_W = 18;
   localparam int DATA_W = 32;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Register offsets
   localparam logic [17:0] OFS_SLOT_REG = 18'h00708;
   localparam logic [17:0] OFS_AF_LOW = 18'h00710;
   localparam logic [17:0] OFS_AF_HIGH = 18'h00714;

   // Table regions, taken from address bits 17:14
   localparam logic [3:0] REGION_TX_VLAN = 4'h1;
   localparam logic [3:0] REGION_RX_VLAN = 4'h2;

   ////////////////////////////////////////////////////////////////////////
   // Slot register fields and reset values
   localparam int ACCEPT_ALL_BIT = 31;
   localparam logic ACCEPT_ALL_RST = 1'b1;
   localparam logic [7:0] SLOT_RST = 8'h00;
   localparam int NUM_FILTERS = 4;
   localparam logic [7:0] SLOT_LAST = 8'h03;
   localparam logic [31:0] AF_LOW_RST = 32'hffffffff;
   localparam logic [15:0] AF_HIGH_RST = 16'hffff;

   ////////////////////////////////////////////////////////////////////////
   // VLAN table geometry and field positions
   localparam int VLAN_DEPTH = 4096;
   localparam int VLAN_IDX_W = 12;
   localparam int VLAN_ENTRY_W = 14;
   localparam int VLAN_TAG_BIT = 0;
   localparam int VLAN_STRIP_BIT = 1;
   localparam int VLAN_TRANS_LSB = 2;
   localparam int VLAN_TRANS_W = 12;

   // One table entry as laid out in its word
   typedef struct packed {
      logic [VLAN_TRANS_W-1:0] trans;
      logic strip;
      logic tag;
   } vlan_entry_s;

   // Register-side access to one table
   typedef struct packed {
      logic we;
      logic [VLAN_IDX_W-1:0] idx;
      logic [VLAN_ENTRY_W-1:0] wdata;
      logic [VLAN_ENTRY_W-1:0] wmask;
   } vlan_req_s;

endpackage
`default_nettype wire

// ==== logic/vlan_table.sv ====
// Purpose: One 4K-entry VLAN table with register and lookup ports
// Assumes: Contents are loaded by software before use
// Notes: Excluded fields are never written and read as zero
`timescale 1ns/1ps
`default_nettype none
module vlan_table
   import rx_filter_pkg::*;
#(
   parameter bit HAS_TRANS = 1'b1,
   parameter bit HAS_STRIP = 1'b1,
   parameter bit HAS_TAG = 1'b1
) (
   // Clock, reset, enable
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic ce,
   // Register side
   input wire vlan_req_s busReq,
   output vlan_entry_s busRdData_ff,
   // Frame side lookup
   input wire logic [VLAN_IDX_W-1:0] lookupIdx,
   output vlan_entry_s lookupData_ff
);

   // Bits that exist in this build; fields never move
   localparam logic [VLAN_ENTRY_W-1:0] PRESENT =
      {{VLAN_TRANS_W{HAS_TRANS}}, HAS_STRIP, HAS_TAG};

   logic [VLAN_ENTRY_W-1:0] mem [0:VLAN_DEPTH-1];
   logic [VLAN_ENTRY_W-1:0] keepMask;
   logic [VLAN_ENTRY_W-1:0] setMask;

   ////////////////////////////////////////////////////////////////////////
   // Byte-lane merge, absent bits never written
   assign setMask = busReq.wmask & PRESENT;
   assign keepMask = ~setMask;

   // No preload: storage has no reset
   always_ff @(posedge clk_sys) begin
      if (ce && busReq.we) begin
         mem[busReq.idx] <= (mem[busReq.idx] & keepMask) |
                            (busReq.wdata & setMask);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registered reads, absent bits forced to zero
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         busRdData_ff <= '0;
         lookupData_ff <= '0;
      end else if (ce) begin
         busRdData_ff <= mem[busReq.idx] & PRESENT;
         lookupData_ff <= mem[lookupIdx] & PRESENT;
      end
   end

endmodule
`default_nettype wire

// ==== logic/rx_addr_filter_vlan_tables.sv ====
// Purpose: Receive address filter registers, matcher and VLAN tables
// Assumes: Register port is AXI4-Lite on clk_sys, one access at a time
// Notes: Unmapped accesses answer SLVERR, reads of them return zero
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Bit 31 accept-all, resets to one
// - Bits 30:8 read zero, writes ignored
// - Low byte picks filter entry zero to three
// - Slot index persists across data accesses
// - Low word holds address bits 31:0
// - High word holds bits 47:32, upper zero
// - Entries compared, first wire byte lowest
// - Transmit table 4K word-aligned entries
// - Entry: 12-bit translation, strip, tag bits
// - Built width 1, 2, 12, 13, 14
// - Absent bits ignore writes, read zero
// - Field positions fixed in every build
// - Receive table mirrors transmit table layout
// - Accept-all skips station unicast check
module rx_addr_filter_vlan_tables
   import rx_filter_pkg::*;
#(
   parameter bit TX_HAS_TRANS = 1'b1,
   parameter bit TX_HAS_STRIP = 1'b1,
   parameter bit TX_HAS_TAG = 1'b1,
   parameter bit RX_HAS_TRANS = 1'b1,
   parameter bit RX_HAS_STRIP = 1'b1,
   parameter bit RX_HAS_TAG = 1'b1
) (
   // Clock, reset, enable
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic ce,
   // AXI4-Lite write address and data
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   // AXI4-Lite write response
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   // AXI4-Lite read
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   // Receive address check
   input wire logic [47:0] stationAddr,
   input wire logic rxDestValid,
   input wire logic [47:0] rxDestAddr,
   output logic rxCheckDone_ff,
   output logic rxAccept_ff,
   output logic acceptAllMode_ff,
   // VLAN lookups
   input wire logic [VLAN_IDX_W-1:0] txVlanId,
   output vlan_entry_s txVlanEntry,
   input wire logic [VLAN_IDX_W-1:0] rxVlanId,
   output vlan_entry_s rxVlanEntry
);

   typedef enum logic [2:0] {
      BUS_IDLE, BUS_WR, BUS_BRESP, BUS_RD, BUS_RDATA, BUS_RRESP
   } bus_state_e;

   bus_state_e state_ff;
   logic [7:0] filterSlot_ff;
   logic [47:0] filterAddr_ff [NUM_FILTERS];
   logic [ADDR_W-1:0] rdAddr_ff;
   logic [NUM_FILTERS-1:0] entryHit;
   logic wrGo;
   logic slotValid;
   logic [31:0] strobeMask;
   logic [ADDR_W-1:0] accAddr;
   logic [3:0] accRegion;
   vlan_req_s txReq;
   vlan_req_s rxReq;
   vlan_entry_s txBusRd;
   vlan_entry_s rxBusRd;
   logic [31:0] nxt_rdata;
   logic nxt_rdErr;

   ////////////////////////////////////////////////////////////////////////
   // Access decode
   assign wrGo = (state_ff == BUS_WR) && s_axi_awvalid && s_axi_wvalid;
   assign slotValid = filterSlot_ff <= SLOT_LAST;
   assign strobeMask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                        {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
   assign accAddr = (state_ff == BUS_WR) ? s_axi_awaddr : s_axi_araddr;
   assign accRegion = accAddr[ADDR_W-1:ADDR_W-4];

   // Table requests: word-aligned index from address bits 13:2
   always_comb begin
      txReq.idx = accAddr[VLAN_IDX_W+1:2];
      txReq.wdata = s_axi_wdata[VLAN_ENTRY_W-1:0];
      txReq.wmask = strobeMask[VLAN_ENTRY_W-1:0];
      txReq.we = wrGo && (accRegion == REGION_TX_VLAN);
      rxReq = txReq;
      rxReq.we = wrGo && (accRegion == REGION_RX_VLAN);
   end

   ////////////////////////////////////////////////////////////////////////
   // Bus sequencer, write has priority over read
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         state_ff <= BUS_IDLE;
      end else if (ce) begin
         unique case (state_ff)
            BUS_IDLE: begin
               if (s_axi_awvalid && s_axi_wvalid) begin
                  state_ff <= BUS_WR;
               end else if (s_axi_arvalid) begin
                  state_ff <= BUS_RD;
               end
            end
            BUS_WR: state_ff <= BUS_BRESP;
            BUS_BRESP: begin
               if (s_axi_bready) begin
                  state_ff <= BUS_IDLE;
               end
            end
            BUS_RD: state_ff <= BUS_RDATA;
            BUS_RDATA: state_ff <= BUS_RRESP;
            BUS_RRESP: begin
               if (s_axi_rready) begin
                  state_ff <= BUS_IDLE;
               end
            end
         endcase
      end
   end

   // Ready pulses, one cycle in the accept state
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_arready <= 1'b0;
      end else if (ce) begin
         s_axi_awready <= (state_ff == BUS_IDLE) && s_axi_awvalid &&
                          s_axi_wvalid;
         s_axi_wready <= (state_ff == BUS_IDLE) && s_axi_awvalid &&
                         s_axi_wvalid;
         s_axi_arready <= (state_ff == BUS_IDLE) && s_axi_arvalid &&
                          !(s_axi_awvalid && s_axi_wvalid);
      end
   end

   // Write response
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (ce) begin
         if (wrGo) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (s_axi_awaddr == OFS_SLOT_REG ||
                            s_axi_awaddr == OFS_AF_LOW ||
                            s_axi_awaddr == OFS_AF_HIGH ||
                            accRegion == REGION_TX_VLAN ||
                            accRegion == REGION_RX_VLAN) ?
                           RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Slot select and accept-all register
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         acceptAllMode_ff <= ACCEPT_ALL_RST;
         filterSlot_ff <= SLOT_RST;
      end else if (ce && wrGo && s_axi_awaddr == OFS_SLOT_REG) begin
         if (s_axi_wstrb[3]) begin
            acceptAllMode_ff <= s_axi_wdata[ACCEPT_ALL_BIT];
         end
         if (s_axi_wstrb[0]) begin
            filterSlot_ff <= s_axi_wdata[7:0];
         end
      end
   end

   // Filter entries, written through the selected slot
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         for (int i = 0; i < NUM_FILTERS; i++) begin
            filterAddr_ff[i] <= {AF_HIGH_RST, AF_LOW_RST};
         end
      end else if (ce && wrGo && slotValid) begin
         if (s_axi_awaddr == OFS_AF_LOW) begin
            for (int b = 0; b < 4; b++) begin
               if (s_axi_wstrb[b]) begin
                  filterAddr_ff[filterSlot_ff[1:0]][8*b +: 8] <=
                     s_axi_wdata[8*b +: 8];
               end
            end
         end else if (s_axi_awaddr == OFS_AF_HIGH) begin
            for (int b = 0; b < 2; b++) begin
               if (s_axi_wstrb[b]) begin
                  filterAddr_ff[filterSlot_ff[1:0]][32+8*b +: 8] <=
                     s_axi_wdata[8*b +: 8];
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data select
   always_comb begin
      nxt_rdata = '0;
      nxt_rdErr = 1'b0;
      if (rdAddr_ff == OFS_SLOT_REG) begin
         nxt_rdata[ACCEPT_ALL_BIT] = acceptAllMode_ff;
         nxt_rdata[7:0] = filterSlot_ff;
      end else if (rdAddr_ff == OFS_AF_LOW) begin
         if (slotValid) begin
            nxt_rdata = filterAddr_ff[filterSlot_ff[1:0]][31:0];
         end
      end else if (rdAddr_ff == OFS_AF_HIGH) begin
         if (slotValid) begin
            nxt_rdata[15:0] = filterAddr_ff[filterSlot_ff[1:0]][47:32];
         end
      end else if (rdAddr_ff[ADDR_W-1:ADDR_W-4] == REGION_TX_VLAN) begin
         nxt_rdata[VLAN_ENTRY_W-1:0] = txBusRd;
      end else if (rdAddr_ff[ADDR_W-1:ADDR_W-4] == REGION_RX_VLAN) begin
         nxt_rdata[VLAN_ENTRY_W-1:0] = rxBusRd;
      end else begin
         nxt_rdErr = 1'b1;
      end
   end

   // Read address capture and response
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         rdAddr_ff <= '0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (ce) begin
         if (state_ff == BUS_RD) begin
            rdAddr_ff <= s_axi_araddr;
         end
         if (state_ff == BUS_RDATA) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= nxt_rdata;
            s_axi_rresp <= nxt_rdErr ? RESP_SLVERR : RESP_OKAY;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Per-entry destination compare, byte order as stored
   for (genvar g = 0; g < NUM_FILTERS; g++) begin : gen_hit
      assign entryHit[g] = rxDestAddr == filterAddr_ff[g];
   end

   // Accept decision, one cycle after the destination strobe
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         rxCheckDone_ff <= 1'b0;
         rxAccept_ff <= 1'b0;
      end else if (ce) begin
         rxCheckDone_ff <= rxDestValid;
         if (rxDestValid) begin
            if (acceptAllMode_ff) begin
               rxAccept_ff <= 1'b1;
            end else begin
               rxAccept_ff <= (rxDestAddr == stationAddr) ||
                              (|entryHit);
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Transmit and receive VLAN tables
   vlan_table #(
      .HAS_TRANS(TX_HAS_TRANS),
      .HAS_STRIP(TX_HAS_STRIP),
      .HAS_TAG(TX_HAS_TAG)
   ) u_tx_vlan (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .ce(ce),
      .busReq(txReq),
      .busRdData_ff(txBusRd),
      .lookupIdx(txVlanId),
      .lookupData_ff(txVlanEntry)
   );

   vlan_table #(
      .HAS_TRANS(RX_HAS_TRANS),
      .HAS_STRIP(RX_HAS_STRIP),
      .HAS_TAG(RX_HAS_TAG)
   ) u_rx_vlan (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .ce(ce),
      .busReq(rxReq),
      .busRdData_ff(rxBusRd),
      .lookupIdx(rxVlanId),
      .lookupData_ff(rxVlanEntry)
   );

endmodule
`default_nettype wire

// ==== bench/rx_addr_filter_vlan_tables_checker.sv ====
// Purpose: Port checks for the receive filter block
// Assumes: Sees only the top module ports
// Notes: Bound from the bench top file
`timescale 1ns/1ps
`default_nettype none
module rx_addr_filter_vlan_tables_checker
   import rx_filter_pkg::*;
(
   // Clock, reset, enable
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic ce,
   // Register port
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [DATA_W-1:0] s_axi_rdata,
   // Address check
   input wire logic [47:0] stationAddr,
   input wire logic rxDestValid,
   input wire logic [47:0] rxDestAddr,
   input wire logic rxCheckDone_ff,
   input wire logic rxAccept_ff,
   input wire logic acceptAllMode_ff
);
   ////////////////////////////////////////
   // Shared timing
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn || !ce);

   // Read data two cycles after the address is taken
   sequence readAnswer;
      ##2 s_axi_rvalid;
   endsequence

   ////////////////////////////////////////
   // Register port
   write_resp_a: assert property (
      s_axi_awready |=> s_axi_bvalid) else $error("no write response");
   ready_pair_a: assert property (
      s_axi_awready == s_axi_wready) else $error("write readies split");
   resp_hold_a: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   read_latency_a: assert property (
      s_axi_arready |-> readAnswer) else $error("read answer late");
   rdata_hold_a: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");

   ////////////////////////////////////////
   // Address check
   check_done_a: assert property (
      rxDestValid |=> rxCheckDone_ff) else $error("check not done");
   done_pulse_a: assert property (
      !rxDestValid |=> !rxCheckDone_ff) else $error("stray check done");
   accept_all_a: assert property (
      rxDestValid && acceptAllMode_ff |=> rxAccept_ff)
      else $error("accept-all frame dropped");
   station_hit_a: assert property (
      rxDestValid && rxDestAddr == stationAddr |=> rxAccept_ff)
      else $error("station frame dropped");
   reset_state_a: assert property (
      @(posedge clk_sys) disable iff (1'b0)
      !resetn && ce |=> acceptAllMode_ff && !rxCheckDone_ff)
      else $error("bad reset state");
endmodule
`default_nettype wire

// ==== bench/rx_addr_filter_vlan_tables_tb.sv ====
// Purpose: Self-checking bench for the receive filter block
// Assumes: Default build, all VLAN fields present
// Notes: Inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none
module rx_addr_filter_vlan_tables_tb
   import rx_filter_pkg::*;
;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic ce = 1'b1;
   logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_rready, rxDestValid, s_axi_awready, s_axi_wready;
   logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic rxCheckDone_ff, rxAccept_ff, acceptAllMode_ff;
   logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic [47:0] stationAddr, rxDestAddr;
   logic [VLAN_IDX_W-1:0] txVlanId, rxVlanId;
   vlan_entry_s txVlanEntry, rxVlanEntry;
   int n_mismatch = 0;
   int comparisons = 0;
   int cycles = 0;

   rx_addr_filter_vlan_tables rx_addr_filter_vlan_tables_i (.clk_sys,
      .resetn, .ce, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
      .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
      .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
      .s_axi_rdata, .s_axi_rresp, .stationAddr, .rxDestValid, .rxDestAddr,
      .rxCheckDone_ff, .rxAccept_ff, .acceptAllMode_ff, .txVlanId,
      .txVlanEntry, .rxVlanId, .rxVlanEntry);

   ////////////////////////////////////////
   // Clock and hang limit
   always #50 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         n_mismatch++;
         report_and_stop();
      end
   end

   ////////////////////////////////////////
   // Shared helpers
   task automatic chk(input string what, input logic [31:0] exp, got);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   // Register write, holds valid until ready seen
   task automatic wr(input logic [17:0] a, input logic [31:0] d,
                     input logic [3:0] s);
      @(negedge clk_sys);
      s_axi_awaddr = a;
      s_axi_wdata = d;
      s_axi_wstrb = s;
      s_axi_awvalid = 1'b1;
      s_axi_wvalid = 1'b1;
      @(negedge clk_sys);
      while (!s_axi_awready) @(negedge clk_sys);
      @(negedge clk_sys);
      s_axi_awvalid = 1'b0;
      s_axi_wvalid = 1'b0;
      while (!s_axi_bvalid) @(negedge clk_sys);
      @(negedge clk_sys); // Stall one cycle, response must hold
      s_axi_bready = 1'b1;
      resp = s_axi_bresp;
      @(negedge clk_sys);
      s_axi_bready = 1'b0;
   endtask

   // Register read and compare
   task automatic rdchk(input logic [17:0] a, input logic [31:0] exp,
                        input logic [1:0] er);
      @(negedge clk_sys);
      s_axi_araddr = a;
      s_axi_arvalid = 1'b1;
      @(negedge clk_sys);
      while (!s_axi_arready) @(negedge clk_sys);
      @(negedge clk_sys);
      s_axi_arvalid = 1'b0;
      while (!s_axi_rvalid) @(negedge clk_sys);
      @(negedge clk_sys); // Stall one cycle, data must hold
      s_axi_rready = 1'b1;
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      @(negedge clk_sys);
      s_axi_rready = 1'b0;
      chk("rdata", exp, rd);
      chk("rresp", {30'h0, er}, {30'h0, resp});
   endtask

   // One destination check
   task automatic dest(input logic [47:0] a, input logic exp);
      @(negedge clk_sys);
      rxDestAddr = a;
      rxDestValid = 1'b1;
      @(negedge clk_sys);
      rxDestValid = 1'b0;
      chk("rxCheckDone", 32'h1, {31'h0, rxCheckDone_ff});
      chk("rxAccept", {31'h0, exp}, {31'h0, rxAccept_ff});
   endtask

   ////////////////////////////////////////
   // Scenarios
   task automatic t_reset();
      chk("acceptAll", 32'h1, {31'h0, acceptAllMode_ff});
      rdchk(18'h00708, 32'h80000000, RESP_OKAY);
      rdchk(18'h00710, 32'hffffffff, RESP_OKAY);
      rdchk(18'h00714, 32'h0000ffff, RESP_OKAY);
   endtask

   task automatic t_slot();
      wr(18'h00708, 32'h7fffff03, 4'hf);
      chk("bresp", {30'h0, RESP_OKAY}, {30'h0, resp});
      rdchk(18'h00708, 32'h00000003, RESP_OKAY);
      chk("acceptAll", 32'h0, {31'h0, acceptAllMode_ff});
   endtask

   task automatic t_filters();
      for (int i = 0; i < 4; i++) begin
         wr(18'h00708, i, 4'h1);
         wr(18'h00710, 32'h44332210 + i, 4'hf);
         wr(18'h00714, 32'hffff6655, 4'hf);
      end
      wr(18'h00708, 32'h2, 4'h1);
      rdchk(18'h00710, 32'h44332212, RESP_OKAY);
      rdchk(18'h00714, 32'h00006655, RESP_OKAY);
      rdchk(18'h00710, 32'h44332212, RESP_OKAY);
      wr(18'h00708, 32'h5, 4'h1);
      rdchk(18'h00710, 32'h0, RESP_OKAY);
   endtask

   task automatic t_match();
      dest(stationAddr, 1'b1);
      dest(48'h665544332213, 1'b1);
      dest(48'h665544332210, 1'b1);
      dest(48'h665544332214, 1'b0);
      wr(18'h00708, 32'h80000000, 4'h8);
      dest(48'h665544332214, 1'b1);
      rdchk(18'h00708, 32'h80000005, RESP_OKAY);
   endtask

   task automatic t_vlan();
      wr(18'h04014, 32'hffffffff, 4'hf);
      rdchk(18'h04014, 32'h00003fff, RESP_OKAY);
      wr(18'h04014, 32'h0, 4'h1);
      rdchk(18'h04014, 32'h00003f00, RESP_OKAY);
      wr(18'h0801c, 32'h0000a5a6, 4'hf);
      rdchk(18'h0801c, 32'h000025a6, RESP_OKAY);
      @(negedge clk_sys);
      txVlanId = 12'h005;
      rxVlanId = 12'h007;
      @(negedge clk_sys);
      chk("txEntry", 32'h3f00, {18'h0, txVlanEntry});
      chk("rxTrans", 32'h969, {20'h0, rxVlanEntry.trans});
      chk("rxStrip", 32'h1, {31'h0, rxVlanEntry.strip});
      chk("rxTag", 32'h0, {31'h0, rxVlanEntry.tag});
      wr(18'h00c00, 32'h1, 4'hf);
      chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
      rdchk(18'h00c00, 32'h0, RESP_SLVERR);
   endtask

   // Clock enable low freezes the address check
   task automatic t_freeze();
      @(negedge clk_sys);
      ce = 1'b0;
      rxDestAddr = stationAddr;
      rxDestValid = 1'b1;
      @(negedge clk_sys);
      chk("frozenDone", 32'h0, {31'h0, rxCheckDone_ff});
      rxDestValid = 1'b0;
      ce = 1'b1;
   endtask

   ////////////////////////////////////////
   // Verdict
   task automatic report_and_stop();
      $display("mismatches %0d, comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      s_axi_awvalid = 1'b0;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      s_axi_awaddr = '0;
      s_axi_araddr = '0;
      s_axi_wdata = '0;
      s_axi_wstrb = 4'h0;
      rxDestValid = 1'b0;
      rxDestAddr = '0;
      stationAddr = 48'h0a0b0c0d0e0f;
      txVlanId = '0;
      rxVlanId = '0;
      repeat (2) @(negedge clk_sys);
      resetn = 1'b1;
      t_reset();
      t_slot();
      t_filters();
      t_match();
      t_vlan();
      t_freeze();
      report_and_stop();
   end
endmodule

bind rx_addr_filter_vlan_tables rx_addr_filter_vlan_tables_checker
   rx_addr_filter_vlan_tables_checker_i (.clk_sys, .resetn, .ce,
   .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
   .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
   .stationAddr, .rxDestValid, .rxDestAddr, .rxCheckDone_ff,
   .rxAccept_ff, .acceptAllMode_ff);
`default_nettype wire
